// ==== common/burst_sram_map.svh ====
// burst_sram_map.svh: constants for the burst sram clock interface
// assumes inclusion by the package, the design file and the bench
`ifndef BURST_SRAM_MAP_SVH
`define BURST_SRAM_MAP_SVH
`define ADDR_W       4
`define WORD_W       18
`define LANE_W       9
`define LANES        2
`define BURST_LEN    2
`define RW_READ      1'b1
`define RW_WRITE     1'b0
`define DLL_LOCK_CYC 8
`endif

// ==== common/burst_sram_pkg.sv ====
// burst_sram_pkg: types shared by the burst sram block
// assumes the map header sits on the include path
`include "burst_sram_map.svh"
package burst_sram_pkg;
    typedef struct packed {
        logic                 load_n;
        logic                 rw;
        logic [`ADDR_W-1:0]   addr;
    } cmd_t;
    typedef struct packed {
        logic [`WORD_W-1:0]   data;
        logic [`LANES-1:0]    byte_write_sel_n;
    } wbeat_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RD_LO,
        ST_RD_HI
    } rd_state_t;
endpackage

// ==== rtl/burst_sram_clock_interface.sv ====
// burst_sram_clock_interface: command, clocking and data path of a burst sram
// assumes all inputs synchronous to clock_i; the four device clocks are phase enables
//
// How it works
// - load_strobe_n low loads an access; rw high means read, low write
// - output clock phases together pace the read words onto the data outputs
// - inputs captured on positive input clock phase; every access begins there
// - negative input clock phase also captures inputs, the second burst word
// - single clock mode paces read data by input clock phases instead
// - positive echo clock follows positive output clock, or input clock when single
// - negative echo clock follows negative output clock, or input clock when single
// - dll_disable_n low holds the lock delay cleared and dll lock low; read timing is unchanged
// - each load moves a burst of two words in one clock period
// - read outputs released (enable high) when no read is pending
// - byte write selects sampled with write data; deselected bytes stay unchanged
`timescale 1ns/100ps
`include "burst_sram_map.svh"
module burst_sram_clock_interface
    import burst_sram_pkg::*;
#(
    parameter int DEPTH = 1 << `ADDR_W
)(
    // clock and reset
    input  wire logic                clock_i,
    input  wire logic                sys_rst_i,
    // clock phase enables from the controller, then single clock and dll mode inputs
    input  wire logic                in_clk_p_i,
    input  wire logic                in_clk_n_i,
    input  wire logic                out_clk_p_i,
    input  wire logic                out_clk_n_i,
    input  wire logic                single_clock_i,
    input  wire logic                dll_disable_n_i,
    // command and write data
    input  wire cmd_t                cmd_i,
    input  wire wbeat_t              wbeat_i,
    // read data, output enable, echo clocks and dll lock
    output logic [`WORD_W-1:0]       rdata_o,
    output logic                     rdata_oe_n_o,
    output logic                     echo_clk_p_o,
    output logic                     echo_clk_n_o,
    output logic                     dll_locked_o
);
    logic [`WORD_W-1:0] mem_q [DEPTH];
    logic [`ADDR_W-1:0] rd_addr_q;
    logic [`ADDR_W-1:0] wr_addr_q;
    logic               wr_hi_q;
    logic [`ADDR_W-1:0] hi_addr_q;
    logic               rd_pend_q;
    rd_state_t          rd_state_q;
    logic [`WORD_W-1:0] rdata_q;
    logic               oe_n_q;
    logic               ecp_q;
    logic               ecn_q;
    logic [3:0]         lock_cnt_q;
    logic               locked_q;

    function automatic logic [`WORD_W-1:0] merge(input logic [`WORD_W-1:0] old_w,
                                                 input wbeat_t b);
        logic [`WORD_W-1:0] r;
        r = old_w;
        for (int i = 0; i < `LANES; i++)
            if (!b.byte_write_sel_n[i])
                r[i*`LANE_W +: `LANE_W] = b.data[i*`LANE_W +: `LANE_W];
        return r;
    endfunction

    // address bit 0 never steers a burst; the beat picks the word of the pair
    function automatic logic [`ADDR_W-1:0] pair_addr(input logic [`ADDR_W-1:0] a,
                                                      input logic odd);
        return {a[`ADDR_W-1:1], odd};
    endfunction

    // single clock mode swaps the output pacing source
    wire pace_p = single_clock_i ? in_clk_p_i : out_clk_p_i;
    wire pace_n = single_clock_i ? in_clk_n_i : out_clk_n_i;
    wire load   = in_clk_p_i && !cmd_i.load_n;
    wire rd_req = load && (cmd_i.rw == `RW_READ);
    wire wr_req = load && (cmd_i.rw == `RW_WRITE);
    wire rd_busy = (rd_state_q != ST_IDLE);
    wire [`ADDR_W-1:0] wa_load = pair_addr(cmd_i.addr, 1'b0);
    wire [`ADDR_W-1:0] wa_hi   = pair_addr(wr_addr_q, 1'b1);
    wire [`ADDR_W-1:0] ra_lo   = pair_addr(rd_addr_q, 1'b0);
    // high word keeps its own address so a queued load cannot steer it
    wire [`ADDR_W-1:0] ra_hi   = pair_addr(hi_addr_q, 1'b1);
    wire lock_done = (lock_cnt_q == 4'(`DLL_LOCK_CYC));

    // write path: first word on positive phase with the load, second on negative
    always_ff @(posedge clock_i)
    begin
        if (wr_req)
            mem_q[wa_load] <= merge(mem_q[wa_load], wbeat_i);
        else if (wr_hi_q && in_clk_n_i)
            mem_q[wa_hi] <= merge(mem_q[wa_hi], wbeat_i);
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            wr_addr_q <= '0;
            wr_hi_q   <= 1'b0;
        end
        else if (wr_req)
        begin
            wr_addr_q <= cmd_i.addr;
            wr_hi_q   <= 1'b1;
        end
        else if (in_clk_n_i)
        begin
            wr_hi_q <= 1'b0;
        end
    end

    // read path: burst of two words paced by the selected clock pair
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            rd_state_q <= ST_IDLE;
            rd_addr_q  <= '0;
            hi_addr_q  <= '0;
            rd_pend_q  <= 1'b0;
            rdata_q    <= '0;
            oe_n_q     <= 1'b1;
        end
        else
        begin
            if (rd_req)
                rd_addr_q <= cmd_i.addr;
            // one load may wait behind a busy burst; two in one burst is a misuse
            if (rd_req && rd_busy)
                rd_pend_q <= 1'b1;
            case (rd_state_q)
                ST_IDLE:
                begin
                    if (rd_req)
                        rd_state_q <= ST_RD_LO;
                    else if (pace_p)
                        oe_n_q <= 1'b1;
                end
                ST_RD_LO:
                begin
                    if (pace_p)
                    begin
                        rdata_q    <= mem_q[ra_lo];
                        hi_addr_q  <= rd_addr_q;
                        oe_n_q     <= 1'b0;
                        rd_state_q <= ST_RD_HI;
                    end
                end
                ST_RD_HI:
                begin
                    if (pace_n)
                    begin
                        rdata_q    <= mem_q[ra_hi];
                        rd_pend_q  <= 1'b0;
                        rd_state_q <= (rd_req || rd_pend_q) ? ST_RD_LO : ST_IDLE;
                    end
                end
                default: rd_state_q <= ST_IDLE;
            endcase
        end
    end

    // echo clocks run free; not reset-gated beyond a defined start value
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            ecp_q <= 1'b0;
            ecn_q <= 1'b0;
        end
        else
        begin
            ecp_q <= pace_p;
            ecn_q <= pace_n;
        end
    end

    // lock delay stands in for the dll; held cleared with lock low while the dll is off
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            lock_cnt_q <= '0;
            locked_q   <= 1'b0;
        end
        else if (!dll_disable_n_i)
        begin
            lock_cnt_q <= '0;
            locked_q   <= 1'b0;
        end
        else
        begin
            if (!lock_done)
                lock_cnt_q <= lock_cnt_q + 4'h1;
            locked_q <= lock_done;
        end
    end

    assign rdata_o      = rdata_q;
    assign rdata_oe_n_o = oe_n_q;
    assign echo_clk_p_o = ecp_q;
    assign echo_clk_n_o = ecn_q;
    assign dll_locked_o = locked_q;

    // checks
    sequence s_read_load;
        rd_req && rd_state_q == ST_IDLE;
    endsequence

    sequence s_lo_word;
        rd_state_q == ST_RD_LO && pace_p;
    endsequence

    a_echo_p_follow: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        pace_p |=> echo_clk_p_o) else $error("echo p missed pace");
    a_echo_n_follow: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !pace_n |=> !echo_clk_n_o) else $error("echo n spurious");
    a_read_drives: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        s_read_load ##[1:4] s_lo_word |=> !rdata_oe_n_o) else $error("read not driven");
    a_read_state: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        s_read_load |=> rd_state_q == ST_RD_LO) else $error("read not loaded");
    a_write_no_read: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        wr_req && rd_state_q == ST_IDLE |=> rd_state_q == ST_IDLE) else $error("write read");
    a_idle_release: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        rd_state_q == ST_IDLE && !rd_req && pace_p |=> rdata_oe_n_o) else $error("no tristate");
    a_dll_off: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !dll_disable_n_i |=> !dll_locked_o) else $error("dll off still locked");
    a_lock_count: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        dll_locked_o |-> lock_cnt_q == 4'(`DLL_LOCK_CYC)) else $error("lock early");
    a_wr_second: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        wr_req |=> wr_hi_q) else $error("second beat lost");
    a_read_queued: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        rd_req && rd_busy |=> rd_pend_q || rd_state_q == ST_RD_LO) else $error("read lost");
endmodule // burst_sram_clock_interface

// ==== verification/mem_ctrl_model.sv ====
// mem_ctrl_model: controller model driving clock phases, loads and write beats
// assumes the bench sets requests on the falling edge with non-blocking assignments
`timescale 1ns/100ps
module mem_ctrl_model
    import burst_sram_pkg::*;
(
    // clock and reset
    input  wire logic   clock_i,
    input  wire logic   sys_rst_i,
    // requests from the bench
    input  wire logic   req_i,
    input  wire cmd_t   req_cmd_i,
    input  wire wbeat_t beat0_i,
    input  wire wbeat_t beat1_i,
    input  wire logic   out_clk_en_i,
    // lines to the device
    output logic        in_clk_p_o,
    output logic        in_clk_n_o,
    output logic        out_clk_p_o,
    output logic        out_clk_n_o,
    output cmd_t        cmd_o,
    output wbeat_t      wbeat_o
);
    logic phase_q;
    initial
    begin
        phase_q = 1'b1;
        {in_clk_p_o, in_clk_n_o, out_clk_p_o, out_clk_n_o} = 4'h0;
        cmd_o = '1;
        wbeat_o = '0;
    end
    // idle lines show inverted last values so stale data never looks valid
    always @(negedge clock_i)
    begin
        phase_q <= sys_rst_i | !phase_q;
        in_clk_p_o <= !sys_rst_i & phase_q;
        in_clk_n_o <= !sys_rst_i & !phase_q;
        out_clk_p_o <= !sys_rst_i & phase_q & out_clk_en_i;
        out_clk_n_o <= !sys_rst_i & !phase_q & out_clk_en_i;
        if (!sys_rst_i && phase_q && req_i)
            cmd_o <= '{1'b0, req_cmd_i.rw, req_cmd_i.addr};
        else
            cmd_o <= '{1'b1, !cmd_o.rw, ~cmd_o.addr};
        wbeat_o <= (phase_q && req_i) ? beat0_i : (!cmd_o.load_n ? beat1_i : ~wbeat_o);
    end
endmodule // mem_ctrl_model

// ==== verification/tb_burst_sram_clock_interface.sv ====
// tb_burst_sram_clock_interface: scenario bench for the burst sram block
// assumes the controller model paces phases p, n, p, n from reset release
`timescale 1ns/100ps
`include "burst_sram_map.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_burst_sram_clock_interface
    import burst_sram_pkg::*;
;
    logic clock_i, sys_rst_i, req, out_clk_en, single_clock, dll_disable_n;
    cmd_t req_cmd, cmd;
    wbeat_t beat0, beat1, wbeat;
    logic in_p, in_n, out_p, out_n, oe_n, echo_p, echo_n, locked;
    logic [`WORD_W-1:0] rdata;
    int n_fail = 0;
    int check_count = 0;
    always #25 clock_i = !clock_i;
    mem_ctrl_model ctrl (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_i(req),
        .req_cmd_i(req_cmd), .beat0_i(beat0), .beat1_i(beat1), .out_clk_en_i(out_clk_en),
        .in_clk_p_o(in_p), .in_clk_n_o(in_n), .out_clk_p_o(out_p), .out_clk_n_o(out_n),
        .cmd_o(cmd), .wbeat_o(wbeat));
    burst_sram_clock_interface DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .in_clk_p_i(in_p), .in_clk_n_i(in_n), .out_clk_p_i(out_p), .out_clk_n_i(out_n),
        .single_clock_i(single_clock), .dll_disable_n_i(dll_disable_n), .cmd_i(cmd),
        .wbeat_i(wbeat), .rdata_o(rdata), .rdata_oe_n_o(oe_n), .echo_clk_p_o(echo_p),
        .echo_clk_n_o(echo_n), .dll_locked_o(locked));
    task automatic print_verdict();
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // bounded wait for the edge that takes the load
    task automatic wait_load();
        int i;
        i = 0;
        do
        begin
            @(posedge clock_i);
            i++;
        end while (!(in_p === 1'b1 && cmd.load_n === 1'b0) && i < 20);
        if (i >= 20)
        begin
            n_fail++;
            print_verdict();
        end
    endtask
    task automatic issue(input logic rw, input logic [3:0] a, input wbeat_t b0, b1);
        @(negedge clock_i);
        req <= 1'b1;
        req_cmd <= '{1'b0, rw, a};
        beat0 <= b0;
        beat1 <= b1;
        wait_load();
        @(negedge clock_i);
        req <= 1'b0;
    endtask
    task automatic read_chk(input logic [3:0] a, input logic [17:0] lo, hi);
        issue(1'b1, a, '1, '1);
        repeat (2) @(negedge clock_i);
        `CHK("rdata low", lo, rdata)
        `CHK("oe_n busy", 1'b0, oe_n)
        `CHK("echo_p", 1'b1, echo_p)
        @(negedge clock_i);
        `CHK("rdata high", hi, rdata)
        `CHK("echo_n", 1'b1, echo_n)
        `CHK("echo_p low", 1'b0, echo_p)
        @(negedge clock_i);
        `CHK("oe_n idle", 1'b1, oe_n)
    endtask
    task automatic t_lock();
        repeat (2) @(negedge clock_i);
        `CHK("locked early", 1'b0, locked)
        repeat (8) @(negedge clock_i);
        `CHK("locked", 1'b1, locked)
    endtask
    task automatic t_write_read();
        issue(1'b0, 4'h2, {18'h12345, 2'b00}, {18'h2ABCD, 2'b00});
        read_chk(4'h3, 18'h12345, 18'h2ABCD);
    endtask
    task automatic t_lanes();
        issue(1'b0, 4'h4, {18'h12345, 2'b00}, {18'h2ABCD, 2'b00});
        issue(1'b0, 4'h5, {18'h00000, 2'b10}, {18'h3FFFF, 2'b01});
        read_chk(4'h4, {9'h091, 9'h000}, {9'h1FF, 9'h1CD});
    endtask
    // second read load lands while the first burst drives its low word
    task automatic t_read_pair();
        @(negedge clock_i);
        req <= 1'b1;
        req_cmd <= '{1'b0, 1'b1, 4'h2};
        wait_load();
        @(negedge clock_i);
        req_cmd <= '{1'b0, 1'b1, 4'h4};
        repeat (2) @(negedge clock_i);
        req <= 1'b0;
        `CHK("pair low a", 18'h12345, rdata)
        @(negedge clock_i);
        `CHK("pair high a", 18'h2ABCD, rdata)
        @(negedge clock_i);
        `CHK("pair low b", {9'h091, 9'h000}, rdata)
        `CHK("pair oe_n", 1'b0, oe_n)
        @(negedge clock_i);
        `CHK("pair high b", {9'h1FF, 9'h1CD}, rdata)
        @(negedge clock_i);
        `CHK("pair oe_n idle", 1'b1, oe_n)
    endtask
    // reads paced by input phases only; echoes stand still without any pace
    task automatic t_single();
        @(negedge clock_i);
        out_clk_en <= 1'b0;
        single_clock <= 1'b1;
        read_chk(4'h2, 18'h12345, 18'h2ABCD);
        single_clock <= 1'b0;
        repeat (2) @(negedge clock_i);
        repeat (2)
        begin
            @(negedge clock_i);
            `CHK("echo_p still", 1'b0, echo_p)
            `CHK("echo_n still", 1'b0, echo_n)
        end
        out_clk_en <= 1'b1;
    endtask
    task automatic t_dll_off();
        @(negedge clock_i);
        dll_disable_n <= 1'b0;
        read_chk(4'h4, {9'h091, 9'h000}, {9'h1FF, 9'h1CD});
        `CHK("locked off", 1'b0, locked)
    endtask
    initial
    begin
        clock_i = 1'b0;
        sys_rst_i = 1'b1;
        req = 1'b0;
        req_cmd = '1;
        beat0 = '0;
        beat1 = '0;
        out_clk_en = 1'b1;
        single_clock = 1'b0;
        dll_disable_n = 1'b1;
        repeat (4) @(negedge clock_i);
        sys_rst_i <= 1'b0;
        t_lock();
        t_write_read();
        t_lanes();
        t_read_pair();
        t_single();
        t_dll_off();
        print_verdict();
    end
endmodule // tb_burst_sram_clock_interface
